/* File: include/adcirq_pkg.sv */
package adcirq_pkg;

	// Register byte offsets
	localparam logic [3:0] ADCIRQ_OFS_STATUS_CONTROL = 4'h0;
	localparam logic [3:0] ADCIRQ_OFS_CONTROL        = 4'h4;
	localparam logic [3:0] ADCIRQ_OFS_RESULT_HIGH    = 4'h8;
	localparam logic [3:0] ADCIRQ_OFS_RESULT_LOW     = 4'hC;
	localparam logic [3:0] ADCIRQ_OFS_PIN_ENABLE     = 4'h0;
	localparam logic [1:0] ADCIRQ_PAGE_MAIN          = 2'h0;
	localparam logic [1:0] ADCIRQ_PAGE_AUX           = 2'h1;
	localparam logic [3:0] ADCIRQ_OFS_IRQ_STATUS     = 4'h4;
	localparam logic [3:0] ADCIRQ_OFS_IRQ_MASK       = 4'h8;

	// Status and control field positions
	localparam int ADCIRQ_SC_CHAN_LSB   = 0;
	localparam int ADCIRQ_SC_CHAN_W     = 3;
	localparam int ADCIRQ_SC_IE_BIT     = 6;
	localparam int ADCIRQ_SC_CCF_BIT    = 7;
	// Control register field positions
	localparam int ADCIRQ_CTL_PU_BIT    = 7;

	// Reset values
	localparam logic [7:0] ADCIRQ_RST_CONTROL = 8'h00;
	localparam logic [7:0] ADCIRQ_RST_SC      = 8'h00;
	localparam logic [7:0] ADCIRQ_RST_PE      = 8'h00;

	// Result width and timing
	localparam int ADCIRQ_RES_W       = 10;
	localparam int ADCIRQ_SAMPLE_CYC  = 14;
	localparam logic [4:0] ADCIRQ_SAMPLE_LAST = 5'(ADCIRQ_SAMPLE_CYC - 1);
	localparam logic [3:0] ADCIRQ_SAR_LAST    = 4'(ADCIRQ_RES_W - 1);

	// Interrupt status bits
	localparam int ADCIRQ_EV_DONE  = 0;
	localparam int ADCIRQ_EV_ABORT = 1;
	localparam int ADCIRQ_EV_W     = 2;

	typedef enum logic [1:0] {
		ADCIRQ_IDLE,
		ADCIRQ_SAMPLE,
		ADCIRQ_CONVERT
	} adcirq_state_t;

	// Avalon-MM request group
	typedef struct packed {
		logic [5:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
	} adcirq_req_t;

	// Link to the successive-approximation engine
	typedef struct packed {
		logic [2:0] channel;
		logic       sample;
		logic       trial_valid;
		logic [9:0] trial;
		logic       power_up;
	} adcirq_eng_out_t;

endpackage

/* File: design/adcirq_sar.sv */
`timescale 1ns/1ps
`default_nettype none

// Successive approximation register with abort
module adcirq_sar
	import adcirq_pkg::*;
(
	// Clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      rstn,
	// Control
	input  wire logic                      start,
	input  wire logic                      abort,
	input  wire logic                      compare_hi,
	// Result
	output logic [ADCIRQ_RES_W-1:0]        trial,
	output logic                           done
);
	typedef struct packed {
		logic [ADCIRQ_RES_W-1:0] sar;
		logic [3:0]              bit_idx;
		logic                    busy;
		logic                    done;
	} adcirq_sar_st_t;

	adcirq_sar_st_t st_reg;
	adcirq_sar_st_t st_next;

	// One bit decided per cycle, MSB first
	always_comb begin
		st_next = st_reg;
		st_next.done = 1'b0;
		if (abort) begin
			st_next.sar = '0;
			st_next.busy = 1'b0;
			st_next.bit_idx = '0;
		end else if (start) begin
			st_next.sar = '0;
			st_next.sar[ADCIRQ_RES_W-1] = 1'b1;
			st_next.bit_idx = ADCIRQ_SAR_LAST;
			st_next.busy = 1'b1;
		end else if (st_reg.busy) begin
			if (!compare_hi) begin
				st_next.sar[st_reg.bit_idx] = 1'b0;
			end
			if (st_reg.bit_idx == 4'h0) begin
				st_next.busy = 1'b0;
				st_next.done = 1'b1;
			end else begin
				st_next.sar[st_reg.bit_idx - 4'h1] = 1'b1;
				st_next.bit_idx = st_reg.bit_idx - 4'h1;
			end
		end
	end

	// State register
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Next trial, so the registered engine port shows the bit under test
	assign trial = st_next.sar;
	assign done  = st_reg.done;
endmodule

`default_nettype wire

/* File: design/adcirq_top.sv */
// Function
// - System reset restores all registers and leaves the converter powered down.
// - Reset mid-conversion stops it, clears flag, approximation bits and pending interrupt.
// - Setting the power-up bit never reinitialises register contents.
// - Writing the control register aborts a conversion without reset or restart.
// - With interrupt enabled, request rises at conversion end with result already stored.
// - Interrupt request stays high as long as the complete flag is set.
// - Any write to status and control clears the complete flag.
// - Reading the high or low result register clears the complete flag.
// - Status-control write aborts and restarts; pin enable write aborts only. The restart here happens only while the power-up bit is set.
//
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module adcirq_top
	import adcirq_pkg::*;
(
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rstn,
	// Avalon-MM slave
	input  wire logic [5:0]            avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	output logic [31:0]                avs_readdata,
	output logic                       avs_waitrequest,
	// Analog engine
	input  wire logic                  eng_compare_hi,
	output adcirq_pkg::adcirq_eng_out_t eng_out,
	// Interrupts
	output logic                       completion_irq,
	output logic                       irq
);
	import adcirq_pkg::*;

	typedef struct packed {
		logic                    ack;
		logic [31:0]             rdata;
		logic [7:0]              converter_control_reg;
		logic [7:0]              converter_status_control_reg;
		logic [7:0]              input_pin_enable_reg;
		logic [ADCIRQ_RES_W-1:0] result;
		adcirq_state_t           state;
		logic [4:0]              sample_cnt;
		logic [ADCIRQ_EV_W-1:0]  ev_status;
		logic [ADCIRQ_EV_W-1:0]  ev_mask;
		logic                    completion_irq;
		logic                    irq;
		adcirq_eng_out_t         eng_out;
	} adcirq_st_t;

	adcirq_st_t st_reg;
	adcirq_st_t st_next;

	adcirq_req_t             req;
	logic [ADCIRQ_RES_W-1:0] sar_trial;
	logic                    sar_done;
	logic                    sar_start;
	logic                    sar_abort;

	// Bus request bundle
	assign req = '{address: avs_address, read: avs_read, write: avs_write, writedata: avs_writedata};

	// Decoded accesses, valid only in the taking cycle
	logic       take;
	logic [1:0] page;
	logic [3:0] ofs;
	logic       wr_sc;
	logic       wr_ctl;
	logic       wr_pe;
	logic       wr_ist;
	logic       wr_msk;
	logic       rd_res;
	logic       powered;
	logic       busy;

	always_comb begin
		take   = (req.read || req.write) && !st_reg.ack;
		page   = req.address[5:4];
		ofs    = req.address[3:0];
		wr_sc  = 1'b0;
		wr_ctl = 1'b0;
		wr_pe  = 1'b0;
		wr_ist = 1'b0;
		wr_msk = 1'b0;
		rd_res = 1'b0;
		if (take && req.write && page == ADCIRQ_PAGE_MAIN && ofs == ADCIRQ_OFS_STATUS_CONTROL) begin
			wr_sc = 1'b1;
		end else if (take && req.write && page == ADCIRQ_PAGE_MAIN && ofs == ADCIRQ_OFS_CONTROL) begin
			wr_ctl = 1'b1;
		end else if (take && req.write && page == ADCIRQ_PAGE_AUX && ofs == ADCIRQ_OFS_PIN_ENABLE) begin
			wr_pe = 1'b1;
		end else if (take && req.write && page == ADCIRQ_PAGE_AUX && ofs == ADCIRQ_OFS_IRQ_STATUS) begin
			wr_ist = 1'b1;
		end else if (take && req.write && page == ADCIRQ_PAGE_AUX && ofs == ADCIRQ_OFS_IRQ_MASK) begin
			wr_msk = 1'b1;
		end else if (take && req.read && page == ADCIRQ_PAGE_MAIN
			&& (ofs == ADCIRQ_OFS_RESULT_HIGH || ofs == ADCIRQ_OFS_RESULT_LOW)) begin
			rd_res = 1'b1;
		end
		powered = st_reg.converter_control_reg[ADCIRQ_CTL_PU_BIT];
		busy    = st_reg.state != ADCIRQ_IDLE;
	end

	// Engine control: any of these writes ends a running conversion
	assign sar_abort = busy && (wr_sc || wr_ctl || wr_pe || !powered);
	assign sar_start = st_reg.state == ADCIRQ_SAMPLE && st_reg.sample_cnt == ADCIRQ_SAMPLE_LAST;

	adcirq_sar u_sar (
		.sys_clk    (sys_clk),
		.rstn       (rstn),
		.start      (sar_start),
		.abort      (sar_abort),
		.compare_hi (eng_compare_hi),
		.trial      (sar_trial),
		.done       (sar_done)
	);

	// Next-state logic for bus, conversion and interrupts
	always_comb begin
		logic       ccf;
		logic [1:0] ev_set;
		ccf    = 1'b0;
		ev_set = '0;
		st_next = st_reg;
		st_next.ack = take;
		st_next.rdata = '0;

		// Read data
		if (take && req.read) begin
			if (page == ADCIRQ_PAGE_MAIN && ofs == ADCIRQ_OFS_STATUS_CONTROL) begin
				st_next.rdata[7:0] = st_reg.converter_status_control_reg;
			end else if (page == ADCIRQ_PAGE_MAIN && ofs == ADCIRQ_OFS_CONTROL) begin
				st_next.rdata[7:0] = st_reg.converter_control_reg;
			end else if (page == ADCIRQ_PAGE_MAIN && ofs == ADCIRQ_OFS_RESULT_HIGH) begin
				st_next.rdata[1:0] = st_reg.result[ADCIRQ_RES_W-1:8];
			end else if (page == ADCIRQ_PAGE_MAIN && ofs == ADCIRQ_OFS_RESULT_LOW) begin
				st_next.rdata[7:0] = st_reg.result[7:0];
			end else if (page == ADCIRQ_PAGE_AUX && ofs == ADCIRQ_OFS_PIN_ENABLE) begin
				st_next.rdata[7:0] = st_reg.input_pin_enable_reg;
			end else if (page == ADCIRQ_PAGE_AUX && ofs == ADCIRQ_OFS_IRQ_STATUS) begin
				st_next.rdata[ADCIRQ_EV_W-1:0] = st_reg.ev_status;
			end else if (page == ADCIRQ_PAGE_AUX && ofs == ADCIRQ_OFS_IRQ_MASK) begin
				st_next.rdata[ADCIRQ_EV_W-1:0] = st_reg.ev_mask;
			end
		end

		// Register writes; power-up only gates the engine, nothing reinitialised
		if (wr_ctl) begin
			st_next.converter_control_reg = req.writedata[7:0];
		end
		if (wr_pe) begin
			st_next.input_pin_enable_reg = req.writedata[7:0];
		end
		if (wr_msk) begin
			st_next.ev_mask = req.writedata[ADCIRQ_EV_W-1:0];
		end

		// Conversion sequencing
		case (st_reg.state)
			ADCIRQ_IDLE: begin
				st_next.sample_cnt = '0;
			end
			ADCIRQ_SAMPLE: begin
				st_next.sample_cnt = st_reg.sample_cnt + 5'h01;
				if (sar_start) begin
					st_next.state = ADCIRQ_CONVERT;
				end
			end
			ADCIRQ_CONVERT: begin
				if (sar_done) begin
					st_next.result = sar_trial;
					st_next.state = ADCIRQ_IDLE;
					ccf = 1'b1;
					ev_set[ADCIRQ_EV_DONE] = 1'b1;
				end
			end
			default: begin
				st_next.state = ADCIRQ_IDLE;
			end
		endcase
		if (sar_abort) begin
			st_next.state = ADCIRQ_IDLE;
			st_next.sample_cnt = '0;
			ccf = 1'b0;
			ev_set[ADCIRQ_EV_ABORT] = 1'b1;
		end

		// Status-control write clears the flag and, when powered, restarts sampling
		if (wr_sc) begin
			st_next.converter_status_control_reg = req.writedata[7:0];
			st_next.converter_status_control_reg[ADCIRQ_SC_CCF_BIT] = 1'b0;
			if (powered) begin
				st_next.state = ADCIRQ_SAMPLE;
				st_next.sample_cnt = '0;
			end
		end

		// Result read clears the flag; completion set wins
		if (rd_res) begin
			st_next.converter_status_control_reg[ADCIRQ_SC_CCF_BIT] = 1'b0;
		end
		if (ccf) begin
			st_next.converter_status_control_reg[ADCIRQ_SC_CCF_BIT] = 1'b1;
		end

		// Sticky events, write one to clear, set wins
		st_next.ev_status = (st_reg.ev_status & ~(wr_ist ? req.writedata[ADCIRQ_EV_W-1:0] : '0)) | ev_set;

		// Level request follows the flag and its enable
		st_next.completion_irq = st_next.converter_status_control_reg[ADCIRQ_SC_CCF_BIT]
			&& st_next.converter_status_control_reg[ADCIRQ_SC_IE_BIT];
		st_next.irq = |(st_next.ev_status & st_next.ev_mask);

		// Engine outputs
		st_next.eng_out.power_up = st_next.converter_control_reg[ADCIRQ_CTL_PU_BIT];
		st_next.eng_out.channel = st_next.converter_status_control_reg[ADCIRQ_SC_CHAN_LSB +: ADCIRQ_SC_CHAN_W];
		st_next.eng_out.sample = st_next.state == ADCIRQ_SAMPLE;
		st_next.eng_out.trial_valid = st_next.state == ADCIRQ_CONVERT; // Aligned with the registered trial
		st_next.eng_out.trial = sar_trial;
	end

	// Reset returns every register to default, powered down, no request
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '0;
			st_reg.converter_control_reg <= ADCIRQ_RST_CONTROL;
			st_reg.converter_status_control_reg <= ADCIRQ_RST_SC;
			st_reg.input_pin_enable_reg <= ADCIRQ_RST_PE;
			st_reg.state <= ADCIRQ_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from flip-flops
	assign avs_readdata    = st_reg.rdata;
	assign avs_waitrequest = !st_reg.ack;
	assign eng_out         = st_reg.eng_out;
	assign completion_irq  = st_reg.completion_irq;
	assign irq             = st_reg.irq;
endmodule

`default_nettype wire

/* File: testbench/adcirq_eng_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Comparator stand-in for the analog front end
module adcirq_eng_model
	import adcirq_pkg::*;
(
	// Clock
	input  wire logic                   sys_clk,
	// Engine link
	input  wire adcirq_pkg::adcirq_eng_out_t eng_out,
	input  wire logic [9:0]             target,
	output var logic                    compare_hi
);
	logic noise = 1'b0;

	// Toggles between trials so a stale compare is never trusted
	always @(posedge sys_clk) begin
		noise <= ~noise;
	end

	// Keep the trial bit while the held input is at or above it
	assign compare_hi = eng_out.trial_valid ? (target >= eng_out.trial) : noise;
endmodule
`default_nettype wire

/* File: testbench/adcirq_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none

// Bus, engine and interrupt relations at the converter ports
module adcirq_top_sva
	import adcirq_pkg::*;
(
	// Clock and reset
	input wire logic                    sys_clk,
	input wire logic                    rstn,
	// Avalon-MM slave
	input wire logic [5:0]              avs_address,
	input wire logic                    avs_read,
	input wire logic                    avs_write,
	input wire logic [31:0]             avs_writedata,
	input wire logic [31:0]             avs_readdata,
	input wire logic                    avs_waitrequest,
	// Engine and interrupts
	input wire logic                    eng_compare_hi,
	input wire adcirq_pkg::adcirq_eng_out_t eng_out,
	input wire logic                    completion_irq,
	input wire logic                    irq
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	// Steps of an access and of the engine
	sequence s_wr(logic [5:0] a);
		avs_write && avs_waitrequest && avs_address == a;
	endsequence
	sequence s_rd_res;
		avs_read && avs_waitrequest && (avs_address == 6'h08 || avs_address == 6'h0C);
	endsequence
	sequence s_quiet;
		!eng_out.sample && !eng_out.trial_valid;
	endsequence

	wake_state_a: assert property ($rose(rstn) |-> eng_out == '0 && !completion_irq && avs_waitrequest)
		else $error("state not cleared by reset");
	ack_latency_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not one cycle after take");
	ctl_abort_a: assert property (s_wr(6'h04) |-> ##[1:3] s_quiet)
		else $error("control write left conversion running");
	pe_abort_a: assert property (s_wr(6'h10) |-> ##[1:3] s_quiet)
		else $error("pin enable write left conversion running");
	sc_start_a: assert property (s_wr(6'h00) ##0 eng_out.power_up |-> ##[1:3] eng_out.sample)
		else $error("status write did not start sampling");
	sc_clear_a: assert property (s_wr(6'h00) |-> ##[1:3] !completion_irq)
		else $error("status write left request set");
	res_clear_a: assert property (s_quiet [*4] ##0 s_rd_res |-> ##[1:3] !completion_irq)
		else $error("result read left request set");
	irq_hold_a: assert property (completion_irq && !(avs_read || avs_write) && !$past(avs_read || avs_write)
		|=> completion_irq)
		else $error("request dropped while flag set");
	done_quiet_a: assert property ($rose(completion_irq) |-> s_quiet)
		else $error("request raised before conversion end");
endmodule

bind adcirq_top adcirq_top_sva u_sva (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .eng_compare_hi(eng_compare_hi), .eng_out(eng_out),
	.completion_irq(completion_irq), .irq(irq));
`default_nettype wire

/* File: testbench/tb_adc_reset_and_completion_irq.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_adc_reset_and_completion_irq;
	import adcirq_pkg::*;
	logic            sys_clk, rstn, avs_read, avs_write, cmp, avs_waitrequest, completion_irq, irq;
	logic [5:0]      avs_address;
	logic [31:0]     avs_writedata, avs_readdata, q;
	logic [9:0]      target;
	logic [2:0]      ch;
	adcirq_eng_out_t eng_out;
	int              n_mismatch = 0;
	int              tests_run = 0;
	int              i;
	integer          seed = 32'hDE69AC31;

	adcirq_top uut (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .eng_compare_hi(cmp), .eng_out(eng_out),
		.completion_irq(completion_irq), .irq(irq));
	adcirq_eng_model u_eng (.sys_clk(sys_clk), .eng_out(eng_out), .target(target), .compare_hi(cmp));

	// Verdict and end of run
	task automatic final_report();
		$display("Mismatches %0d of %0d checks", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic hang(input string nm);
		chk(nm, 32'h0, 32'h1);
		final_report();
	endtask
	// Avalon access held until waitrequest is seen low
	task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
		int k;
		@(posedge sys_clk);
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= d;
		for (k = 0; k < 20; k++) begin
			@(posedge sys_clk);
			if (avs_waitrequest === 1'b0) break;
		end
		if (k == 20) hang("waitrequest");
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	function automatic logic [31:0] exp_res(input logic [9:0] t, input logic hi);
		return hi ? {30'h0, t[9:8]} : {24'h0, t[7:0]};
	endfunction
	// One interrupt-driven conversion with a random input
	task automatic conv(input logic hi_first);
		int k;
		target <= 10'($random(seed));
		ch = 3'($random(seed));
		acc(1'b1, 6'h00, {24'h0, 8'h40 | ch});
		for (k = 0; k < 200 && completion_irq !== 1'b1; k++) @(posedge sys_clk);
		if (k == 200) hang("completion");
		chk("channel", 32'(eng_out.channel), 32'(ch));
		acc(1'b0, 6'h00, 32'h0);
		chk("sc flag", q, {24'h0, 8'hC0 | ch});
		chk("irq held", 32'(completion_irq), 32'h1);
		acc(1'b0, hi_first ? 6'h08 : 6'h0C, 32'h0);
		chk("result a", q, exp_res(target, hi_first));
		repeat (3) @(posedge sys_clk);
		chk("irq after read", 32'(completion_irq), 32'h0);
		acc(1'b0, hi_first ? 6'h0C : 6'h08, 32'h0);
		chk("result b", q, exp_res(target, !hi_first));
	endtask
	// Abort a running conversion by a write elsewhere
	task automatic abort(input logic [5:0] a, input logic [31:0] d);
		acc(1'b1, 6'h14, 32'h3);
		acc(1'b1, 6'h00, 32'h40);
		repeat (8) @(posedge sys_clk);
		acc(1'b1, a, d);
		repeat (40) @(posedge sys_clk);
		chk("no flag after abort", 32'(completion_irq), 32'h0);
		acc(1'b0, 6'h14, 32'h0);
		chk("abort event", q, 32'h2);
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	initial begin
		rstn = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 6'h00;
		avs_writedata = 32'h0;
		target = 10'h000;
		ch = 3'h0;
		repeat (12) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		chk("eng_out reset", 32'(eng_out), 32'h0);
		for (i = 0; i < 16; i++) begin
			acc(1'b0, 6'(i * 4), 32'h0);
			chk("reset read", q, 32'h0);
		end
		acc(1'b1, 6'h00, 32'h45);
		acc(1'b1, 6'h04, 32'h80);
		acc(1'b0, 6'h00, 32'h0);
		chk("sc kept over power up", q, 32'h45);
		for (i = 0; i < 6; i++) conv(i[0]);
		ch = 3'($random(seed));
		acc(1'b1, 6'h00, 32'(ch));
		for (i = 0; i < 60 && q[7] !== 1'b1; i++) acc(1'b0, 6'h00, 32'h0);
		if (i == 60) hang("poll");
		chk("polled flag", q, {24'h0, 8'h80 | ch});
		chk("no irq disabled", 32'(completion_irq), 32'h0);
		acc(1'b1, 6'h00, 32'h40);
		acc(1'b0, 6'h00, 32'h0);
		chk("sc write clears", q, 32'h40);
		abort(6'h04, 32'h80);
		acc(1'b1, 6'h18, 32'h2);
		repeat (3) @(posedge sys_clk);
		chk("irq unmasked", 32'(irq), 32'h1);
		acc(1'b1, 6'h14, 32'h2);
		repeat (3) @(posedge sys_clk);
		chk("irq cleared", 32'(irq), 32'h0);
		abort(6'h10, 32'h0);
		acc(1'b1, 6'h00, 32'h40);
		repeat (10) @(posedge sys_clk);
		conv(1'b1);
		acc(1'b1, 6'h00, 32'h40);
		repeat (20) @(posedge sys_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (40) @(posedge sys_clk);
		chk("eng_out mid reset", 32'(eng_out), 32'h0);
		chk("irq mid reset", 32'(completion_irq), 32'h0);
		for (i = 0; i < 4; i++) begin
			acc(1'b0, 6'(i * 4), 32'h0);
			chk("mid reset read", q, 32'h0);
		end
		final_report();
	end
endmodule
`default_nettype wire
